/* bench/scsp_board_model.sv */
`timescale 1ns/100ps
// board side: open-drain lines with pull-ups, straps and step pins
module scsp_board_model (
  input  wire logic clk_i,
  input  wire logic scl_oe_n_i,
  input  wire logic rst_oe_n_i,
  output logic      scl_o,
  output logic      rst_line_o,
  output logic      step_up_o,
  output logic      step_dn_o,
  output logic      boot_strap_n_o,
  output logic      sel_hi_o,
  output logic      sel_lo_o
);
  logic scl_low;
  logic rst_low;

  // we only ever pull low, so the device's own low drive never fights us
  assign scl_o      = !(scl_low || !scl_oe_n_i);
  assign rst_line_o = !(rst_low || !rst_oe_n_i);

  initial begin
    scl_low        = 1'b0;
    rst_low        = 1'b0;
    step_up_o      = 1'b0;
    step_dn_o      = 1'b0;
    boot_strap_n_o = 1'b1;
    sel_hi_o       = 1'b1;
    sel_lo_o       = 1'b0;
  end

  // strap is set on the same edge as the pull and held past the release edge
  task automatic hold_reset(input int n, input logic boot_n,
                            input logic [1:0] sel);
    @(posedge clk_i);
    rst_low              <= 1'b1;
    boot_strap_n_o       <= boot_n;
    {sel_hi_o, sel_lo_o} <= sel;
    repeat (n) @(posedge clk_i);
    rst_low <= 1'b0;
  endtask : hold_reset

  // pin stays low a few cycles after each step so rises stay distinct
  task automatic pulse(input logic up, input int hi);
    @(posedge clk_i);
    step_up_o <= up;
    step_dn_o <= !up;
    repeat (hi) @(posedge clk_i);
    step_up_o <= 1'b0;
    step_dn_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : pulse

  task automatic scl_pull(input logic low);
    @(posedge clk_i);
    scl_low <= low;
  endtask : scl_pull
endmodule : scsp_board_model

/* bench/tb_top.sv */
`timescale 1ns/100ps
`define SCSP_CHK(nm, e, g) \
  begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        clk, rst_n, hsel, hwrite, hrdy, hresp, scl, scl_oe_n;
  logic        scl_drv, rst_drv;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pll_lock;
  logic [6:0]  i2c_addr, clk_en, m;
  logic        irq_n, rst_line, rst_oe_n, gate_n, ref_lock, g;
  logic        unl1, unl3, unl4, unl_ref, up, dn, boot_n, boot, a_hi, a_lo;
  logic [3:0]  lk, prev;
  logic [23:0] s;
  logic [23:0] ofs [3];
  logic [31:0] e, got;
  string       nm;
  string       nm_q [$];
  logic [31:0] exp_q [$];
  logic [31:0] got_q [$];
  int          error_cnt = 0;
  int          check_count = 0;
  int          seed = 15563;

  scsp_top uut (
    .CLOCK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .SCL_I(scl), .SCL_O(scl_drv),
    .SCL_OE_N_O(scl_oe_n), .ADDR_SELECT_HI_I(a_hi),
    .ADDR_SELECT_LO_I(a_lo), .I2C_ADDR_O(i2c_addr),
    .STATUS_IRQ_N_O(irq_n), .RESET_IO_N_I(rst_line), .RESET_IO_N_O(rst_drv),
    .RESET_IO_N_OE_N_O(rst_oe_n), .OUTPUT_GATE_N_I(gate_n),
    .CLK_OUT_EN_O(clk_en), .PLL_LOCK_I(pll_lock), .REF_LOCK_I(ref_lock),
    .UNLOCK_PLL_FIRST_N_O(unl1), .UNLOCK_PLL_THIRD_N_O(unl3),
    .UNLOCK_PLL_FOURTH_N_O(unl4), .UNLOCK_REFERENCE_O(unl_ref),
    .FREQ_STEP_UP_I(up), .FREQ_STEP_DOWN_I(dn),
    .BOOT_LOADER_STRAP_N_I(boot_n), .BOOT_MODE_O(boot)
  );

  scsp_board_model brd (
    .clk_i(clk), .scl_oe_n_i(scl_oe_n), .rst_oe_n_i(rst_oe_n),
    .scl_o(scl), .rst_line_o(rst_line), .step_up_o(up), .step_dn_o(dn),
    .boot_strap_n_o(boot_n), .sel_hi_o(a_hi), .sel_lo_o(a_lo)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // waits on the bus settle here, where all checks have been compared
  task automatic wrap_up;
    repeat (2) @(posedge clk);
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic note(input string n, input logic [31:0] x,
                      input logic [31:0] y);
    nm_q.push_back(n);
    exp_q.push_back(x);
    got_q.push_back(y);
  endtask : note

  // checker process: oldest note first, off the rising edge
  always @(negedge clk) begin
    while (got_q.size() > 0) begin
      nm  = nm_q.pop_front();
      e   = exp_q.pop_front();
      got = got_q.pop_front();
      `SCSP_CHK(nm, e, got)
    end
  end

  // bounded wait for hready at a rising edge
  task automatic rdy_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 64);
    if (hrdy !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
  endtask : rdy_wait

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= a;
    rdy_wait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy_wait();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] x);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    note($sformatf("reg %h", a), x, r);
    note("hresp", 32'h0, hresp);
  endtask : rd_chk

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    {hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = 3'h2;
    gate_n = 1'b0;
    pll_lock = 3'h7;
    ref_lock = 1'b1;
    for (int j = 0; j < 3; j++) ofs[j] = 24'h000000;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    note("clk_en", 32'h0, clk_en);
    note("rst_oe_n", 32'h0, rst_oe_n);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    note("rst_oe_n", 32'h0, rst_oe_n);
    note("rst_o", 32'h0, rst_drv);
    repeat (12) @(posedge clk);
    note("rst_oe_n", 32'h1, rst_oe_n);
    note("clk_en", 32'h7F, clk_en);
    note("i2c", {scsp_pkg::I2C_ADDR_BASE[6:2], a_hi, a_lo}, i2c_addr);
    rd_chk(scsp_pkg::ADDR_CTRL, scsp_pkg::CTRL_RST);
    rd_chk(scsp_pkg::ADDR_STEP, scsp_pkg::STEP_RST);
    rd_chk(32'h00000040, 32'h0);
    rd_chk(scsp_pkg::ADDR_STATUS, 32'h0052000F);
    // gate pin acts only where the mask bit is set
    for (int i = 0; i < 6; i++) begin
      m = 7'($random(seed));
      g = 1'($random(seed));
      wr(scsp_pkg::ADDR_CTRL, {25'h0, m});
      gate_n <= g;
      repeat (3) @(posedge clk);
      note("clk_en", g ? {25'h0, ~m} : 32'h7F, clk_en);
    end
    gate_n <= 1'b0;
    // lock outputs follow inputs; a change pulls the interrupt low
    prev = 4'hF;
    for (int i = 0; i < 5; i++) begin
      lk = (i == 3) ? prev : 4'($random(seed));
      wr(scsp_pkg::ADDR_EVENT, 32'h1);
      repeat (2) @(posedge clk);
      note("irq_n", 32'h1, irq_n);
      pll_lock <= lk[2:0];
      ref_lock <= lk[3];
      repeat (3) @(posedge clk);
      note("lock", lk, {unl_ref, unl4, unl3, unl1});
      note("irq_n", (lk != prev) ? 32'h0 : 32'h1, irq_n);
      rd_chk(scsp_pkg::ADDR_EVENT, (lk != prev) ? 32'h1 : 32'h0);
      prev = lk;
    end
    // a long high still gives a single step; select 3 steps nothing
    for (int k = 0; k < 4; k++) begin
      s = 24'($random(seed));
      wr(scsp_pkg::ADDR_STEP, {8'h0, s});
      wr(scsp_pkg::ADDR_CTRL, {22'h0, k[1:0], 8'h7F});
      brd.pulse(1'b1, 6);
      brd.pulse(1'b0, 1);
      brd.pulse(1'b0, 2);
      if (k < 3) ofs[k] = ofs[k] - s;
      for (int j = 0; j < 3; j++) begin
        rd_chk(scsp_pkg::ADDR_OFS0 + 32'(4 * j), {8'h0, ofs[j]});
      end
    end
    wr(scsp_pkg::ADDR_CTRL, 32'h0000017F);
    brd.pulse(1'b1, 1);
    ofs[1] = ofs[1] + s;
    rd_chk(scsp_pkg::ADDR_OFS1, {8'h0, ofs[1]});
    brd.pulse(1'b0, 1);
    ofs[1] = ofs[1] - s;
    rd_chk(scsp_pkg::ADDR_OFS1, {8'h0, ofs[1]});
    // stretch only in fast mode, and only for a bounded time
    wr(scsp_pkg::ADDR_CTRL, 32'h0000107F);
    brd.scl_pull(1'b1);
    repeat (3) @(posedge clk);
    note("scl_oe_n", 32'h0, scl_oe_n);
    note("scl_o", 32'h0, scl_drv);
    brd.scl_pull(1'b0);
    repeat (10) @(posedge clk);
    note("scl_oe_n", 32'h1, scl_oe_n);
    wr(scsp_pkg::ADDR_CTRL, 32'h0000007F);
    brd.scl_pull(1'b1);
    repeat (3) @(posedge clk);
    note("scl_oe_n", 32'h1, scl_oe_n);
    brd.scl_pull(1'b0);
    // a low of exactly the filter length must not reset anything
    wr(scsp_pkg::ADDR_STEP, 32'h00000055);
    brd.hold_reset(scsp_pkg::RST_FILT_CYC, 1'b1, 2'b01);
    repeat (3) @(posedge clk);
    // no release, so the old strap value must still stand
    note("i2c", {scsp_pkg::I2C_ADDR_BASE[6:2], 2'b10}, i2c_addr);
    rd_chk(scsp_pkg::ADDR_STEP, 32'h00000055);
    wr(scsp_pkg::ADDR_CTRL, 32'h0000000F);
    fork
      brd.hold_reset(scsp_pkg::RST_FILT_CYC + 10, 1'b0, 2'($random(seed)));
      begin
        repeat (scsp_pkg::RST_FILT_CYC + 6) @(posedge clk);
        note("clk_en", 32'h0, clk_en);
        note("rst_oe_n", 32'h1, rst_oe_n);
      end
    join
    repeat (4) @(posedge clk);
    note("boot", 32'h1, boot);
    note("i2c", {scsp_pkg::I2C_ADDR_BASE[6:2], a_hi, a_lo}, i2c_addr);
    rd_chk(scsp_pkg::ADDR_STEP, scsp_pkg::STEP_RST);
    rd_chk(scsp_pkg::ADDR_OFS1, 32'h0);
    rd_chk(scsp_pkg::ADDR_CTRL, scsp_pkg::CTRL_RST);
    wrap_up();
  end
endmodule : tb_top

/* hw/scsp_pkg.sv */
package scsp_pkg;
  // clock and time figures
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_FILT_NS   = 15000;
  // least time, so round up
  localparam int RST_FILT_CYC  =
    (RST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_HOLD_CYC  = 16;
  localparam int STRETCH_CYC   = 8;
  localparam int CNT_W         = 10;
  localparam int NUM_OUT       = 7;
  localparam int NUM_PLL       = 3;
  localparam int OFS_W         = 24;

  // register byte addresses
  localparam logic [31:0] ADDR_CTRL   = 32'h00000000;
  localparam logic [31:0] ADDR_STEP   = 32'h00000004;
  localparam logic [31:0] ADDR_STATUS = 32'h00000008;
  localparam logic [31:0] ADDR_EVENT  = 32'h0000000C;
  localparam logic [31:0] ADDR_OFS0   = 32'h00000010;
  localparam logic [31:0] ADDR_OFS1   = 32'h00000014;
  localparam logic [31:0] ADDR_OFS2   = 32'h00000018;

  // field positions
  localparam int CTRL_MASK_LSB = 0;
  localparam int CTRL_SEL_LSB  = 8;
  localparam int CTRL_FAST_BIT = 12;
  localparam int STAT_BOOT_BIT = 4;
  localparam int STAT_ADDR_LSB = 16;
  localparam int EVENT_BIT     = 0;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000007F;
  localparam logic [31:0] STEP_RST = 32'h00000001;
  // arbitrary base serial address, low two bits come from straps
  localparam logic [6:0]  I2C_ADDR_BASE = 7'h50;

  // reset controller states
  typedef enum logic [2:0] {
    ST_POR = 3'b001,
    ST_RUN = 3'b010,
    ST_PIN = 3'b100
  } scsp_rst_e;
endpackage : scsp_pkg

/* hw/scsp_step.sv */
`timescale 1ns/100ps
module scsp_step (
  input  wire logic    clk_i,
  input  wire logic    rst_n_i,
  scsp_step_if.stp     st
);
  logic                       up_s1, up_s2, up_s3;
  logic                       dn_s1, dn_s2, dn_s3;
  logic [scsp_pkg::OFS_W-1:0] ofs [scsp_pkg::NUM_PLL];
  logic                       up_edge;
  logic                       dn_edge;
  logic                       do_step;

  // one step, up or down, wraps at the field width
  function automatic logic [scsp_pkg::OFS_W-1:0] step_apply(
    input logic [scsp_pkg::OFS_W-1:0] cur,
    input logic [scsp_pkg::OFS_W-1:0] stp,
    input logic                       up);
    step_apply = up ? cur + stp : cur - stp;
  endfunction : step_apply

  // edge after sync, so a held pin gives a single step
  assign up_edge = up_s2 & ~up_s3;
  assign dn_edge = dn_s2 & ~dn_s3;
  // both at once cancel; select code 3 names no loop
  assign do_step = (up_edge ^ dn_edge) && (st.sel != 2'd3);
  assign st.offs = ofs;

  // two-flop synchroniser plus edge history
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {up_s1, up_s2, up_s3} <= 3'b000;
      {dn_s1, dn_s2, dn_s3} <= 3'b000;
    end else begin
      {up_s1, up_s2, up_s3} <= {st.up_pin, up_s1, up_s2};
      {dn_s1, dn_s2, dn_s3} <= {st.dn_pin, dn_s1, dn_s2};
    end
  end

  // per-loop offset, step size from software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < scsp_pkg::NUM_PLL; i++) ofs[i] <= '0;
    end else if (st.clr) begin
      for (int i = 0; i < scsp_pkg::NUM_PLL; i++) ofs[i] <= '0;
    end else if (do_step) begin
      ofs[st.sel] <= step_apply(ofs[st.sel], st.step, up_edge);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_step_up;
    (up_edge && !dn_edge && !st.clr && st.sel == 2'd0) |=>
      ofs[0] == $past(ofs[0]) + $past(st.step);
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("increment did not add one step");

  property p_step_down;
    (dn_edge && !up_edge && !st.clr && st.sel == 2'd1) |=>
      ofs[1] == $past(ofs[1]) - $past(st.step);
  endproperty
  a_step_down: assert property (p_step_down)
    else $error("decrement did not remove one step");

  sequence s_held_high;
    st.up_pin ##1 st.up_pin [*4];
  endsequence
  property p_held_once;
    (s_held_high and (!st.dn_pin [*5]) and (!st.clr [*5]))
      |=> $stable(ofs[0]) && $stable(ofs[1]) && $stable(ofs[2]);
  endproperty
  a_held_once: assert property (p_held_once)
    else $error("held pin gave more than one step");
endmodule : scsp_step

/* hw/scsp_step_if.sv */
`timescale 1ns/100ps
interface scsp_step_if;
  logic                          clr;
  logic                          up_pin;
  logic                          dn_pin;
  logic [1:0]                    sel;
  logic [scsp_pkg::OFS_W-1:0]    step;
  logic [scsp_pkg::OFS_W-1:0]    offs [scsp_pkg::NUM_PLL];

  modport ctl (output clr, up_pin, dn_pin, sel, step, input offs);
  modport stp (input clr, up_pin, dn_pin, sel, step, output offs);
endinterface : scsp_step_if

/* hw/scsp_top.sv */
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module scsp_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_N_O,
  input  wire logic        ADDR_SELECT_HI_I,
  input  wire logic        ADDR_SELECT_LO_I,
  output logic      [6:0]  I2C_ADDR_O,
  output logic             STATUS_IRQ_N_O,
  input  wire logic        RESET_IO_N_I,
  output logic             RESET_IO_N_O,
  output logic             RESET_IO_N_OE_N_O,
  input  wire logic        OUTPUT_GATE_N_I,
  output logic      [6:0]  CLK_OUT_EN_O,
  input  wire logic [2:0]  PLL_LOCK_I,
  input  wire logic        REF_LOCK_I,
  output logic             UNLOCK_PLL_FIRST_N_O,
  output logic             UNLOCK_PLL_THIRD_N_O,
  output logic             UNLOCK_PLL_FOURTH_N_O,
  output logic             UNLOCK_REFERENCE_O,
  input  wire logic        FREQ_STEP_UP_I,
  input  wire logic        FREQ_STEP_DOWN_I,
  input  wire logic        BOOT_LOADER_STRAP_N_I,
  output logic             BOOT_MODE_O
);
  scsp_pkg::scsp_rst_e           state;
  scsp_pkg::scsp_rst_e           next_state;
  logic [scsp_pkg::CNT_W-1:0]    cnt;
  logic [scsp_pkg::CNT_W-1:0]    next_cnt;
  logic [31:0]                   ctrl;
  logic [31:0]                   step;
  logic                          event_flag;
  logic                          next_event;
  logic [3:0]                    lock_q;
  logic [3:0]                    lock_prev;
  logic                          wr_pend;
  logic [31:0]                   wr_addr;
  logic [3:0]                    scl_cnt;
  logic                          scl_prev;
  logic                          in_reset;
  logic                          pin_low;
  logic                          release_now;
  logic                          addr_ph;
  logic                          wr_ctrl;
  logic                          wr_step;
  logic                          wr_event;
  logic                          status_change;
  logic                          scl_fall;
  logic [31:0]                   rd_mux;
  logic [scsp_pkg::NUM_OUT-1:0]  mask;
  logic [scsp_pkg::NUM_OUT-1:0]  next_en;

  scsp_step_if st ();

  // reset controller decode
  assign in_reset    = (state != scsp_pkg::ST_RUN);
  assign pin_low     = ~RESET_IO_N_I;
  assign release_now = in_reset && (next_state == scsp_pkg::ST_RUN);

  // por stretch, then long-low filter on the pin; short pulses die out
  always_comb begin
    next_state = state;
    next_cnt   = '0;
    unique case (state)
      scsp_pkg::ST_POR: begin
        next_cnt = cnt + 1'b1;
        if (cnt == scsp_pkg::CNT_W'(scsp_pkg::POR_HOLD_CYC - 1)) begin
          next_state = scsp_pkg::ST_RUN;
          next_cnt   = '0;
        end
      end
      scsp_pkg::ST_RUN: begin
        if (pin_low) begin
          next_cnt = cnt + 1'b1;
          // this sample is the one past 15 us of low
          if (cnt == scsp_pkg::CNT_W'(scsp_pkg::RST_FILT_CYC)) begin
            next_state = scsp_pkg::ST_PIN;
            next_cnt   = '0;
          end
        end
      end
      scsp_pkg::ST_PIN: begin
        if (!pin_low) next_state = scsp_pkg::ST_RUN;
      end
    endcase
  end

  // reset controller state
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= scsp_pkg::ST_POR;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // open-drain reset output: enable low only while in power-on
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RESET_IO_N_O      <= 1'b0;
      RESET_IO_N_OE_N_O <= 1'b0;
    end else begin
      RESET_IO_N_O      <= 1'b0;
      RESET_IO_N_OE_N_O <= (next_state != scsp_pkg::ST_POR);
    end
  end

  // straps are caught at release, never under async reset
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      BOOT_MODE_O <= 1'b0;
      I2C_ADDR_O  <= scsp_pkg::I2C_ADDR_BASE;
    end else if (release_now) begin
      BOOT_MODE_O <= ~BOOT_LOADER_STRAP_N_I;
      I2C_ADDR_O  <= {scsp_pkg::I2C_ADDR_BASE[6:2],
                      ADDR_SELECT_HI_I, ADDR_SELECT_LO_I};
    end
  end

  // bus decode
  assign addr_ph  = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign wr_ctrl  = wr_pend && !in_reset && (wr_addr == scsp_pkg::ADDR_CTRL);
  assign wr_step  = wr_pend && !in_reset && (wr_addr == scsp_pkg::ADDR_STEP);
  assign wr_event = wr_pend && (wr_addr == scsp_pkg::ADDR_EVENT);
  assign mask     = ctrl[scsp_pkg::CTRL_MASK_LSB +: scsp_pkg::NUM_OUT];

  // read selection, unmapped words read zero
  always_comb begin
    rd_mux = '0;
    unique case (HADDR_I)
      scsp_pkg::ADDR_CTRL:   rd_mux = ctrl;
      scsp_pkg::ADDR_STEP:   rd_mux = step;
      scsp_pkg::ADDR_STATUS: begin
        rd_mux[3:0] = lock_q;
        rd_mux[scsp_pkg::STAT_BOOT_BIT] = BOOT_MODE_O;
        rd_mux[scsp_pkg::STAT_ADDR_LSB +: 7] = I2C_ADDR_O;
      end
      scsp_pkg::ADDR_EVENT:  rd_mux[scsp_pkg::EVENT_BIT] = event_flag;
      scsp_pkg::ADDR_OFS0:   rd_mux[scsp_pkg::OFS_W-1:0] = st.offs[0];
      scsp_pkg::ADDR_OFS1:   rd_mux[scsp_pkg::OFS_W-1:0] = st.offs[1];
      scsp_pkg::ADDR_OFS2:   rd_mux[scsp_pkg::OFS_W-1:0] = st.offs[2];
      default:               rd_mux = '0;
    endcase
  end

  // zero-wait slave: read data is loaded at the address phase
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_pend     <= 1'b0;
      wr_addr     <= '0;
      HRDATA_O    <= '0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      wr_pend     <= addr_ph && HWRITE_I;
      if (addr_ph) wr_addr <= HADDR_I;
      if (addr_ph && !HWRITE_I) HRDATA_O <= rd_mux;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // config held at defaults for as long as reset lasts
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl <= scsp_pkg::CTRL_RST;
      step <= scsp_pkg::STEP_RST;
    end else if (in_reset) begin
      ctrl <= scsp_pkg::CTRL_RST;
      step <= scsp_pkg::STEP_RST;
    end else begin
      if (wr_ctrl) ctrl <= HWDATA_I;
      if (wr_step) step <= HWDATA_I;
    end
  end

  // lock inputs, registered once in lock_q, to the loss-of-lock pins
  assign UNLOCK_PLL_FIRST_N_O  = lock_q[0];
  assign UNLOCK_PLL_THIRD_N_O  = lock_q[1];
  assign UNLOCK_PLL_FOURTH_N_O = lock_q[2];
  assign UNLOCK_REFERENCE_O    = lock_q[3];
  assign status_change = (lock_q != lock_prev);
  // a new change wins over a same-cycle write-one clear
  assign next_event = in_reset ? 1'b0 :
                      status_change ? 1'b1 :
                      (wr_event && HWDATA_I[scsp_pkg::EVENT_BIT]) ? 1'b0 :
                      event_flag;

  // lock history and sticky status-change flag
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      lock_q         <= 4'h0;
      lock_prev      <= 4'h0;
      event_flag     <= 1'b0;
      STATUS_IRQ_N_O <= 1'b1;
    end else begin
      lock_q         <= {REF_LOCK_I, PLL_LOCK_I};
      lock_prev      <= lock_q;
      event_flag     <= next_event;
      STATUS_IRQ_N_O <= ~next_event;
    end
  end

  // masked outputs follow the gate pin, the rest stay on
  assign next_en = in_reset ? '0 :
                   (~mask | {scsp_pkg::NUM_OUT{~OUTPUT_GATE_N_I}});

  // clock output enables
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) CLK_OUT_EN_O <= '0;
    else           CLK_OUT_EN_O <= next_en;
  end

  // wait states after each falling clock edge in fast mode; the
  // length is fixed, so it only buys time, it tracks no real work
  assign scl_fall = scl_prev && !SCL_I && (scl_cnt == 4'h0) &&
                    ctrl[scsp_pkg::CTRL_FAST_BIT];

  // clock stretch counter, enable low while holding the line
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      scl_prev   <= 1'b1;
      scl_cnt    <= 4'h0;
      SCL_O      <= 1'b0;
      SCL_OE_N_O <= 1'b1;
    end else begin
      scl_prev <= SCL_I;
      SCL_O    <= 1'b0;
      if (scl_fall) begin
        scl_cnt    <= 4'(scsp_pkg::STRETCH_CYC);
        SCL_OE_N_O <= 1'b0;
      end else if (scl_cnt != 4'h0) begin
        scl_cnt    <= scl_cnt - 1'b1;
        SCL_OE_N_O <= (scl_cnt == 4'h1);
      end
    end
  end

  // frequency stepper hookup, cleared while reset lasts
  assign st.clr    = in_reset;
  assign st.up_pin = FREQ_STEP_UP_I;
  assign st.dn_pin = FREQ_STEP_DOWN_I;
  assign st.sel    = ctrl[scsp_pkg::CTRL_SEL_LSB +: 2];
  assign st.step   = step[scsp_pkg::OFS_W-1:0];

  scsp_step u_step (
    .clk_i   (CLOCK_I),
    .rst_n_i (RESETN_I),
    .st      (st.stp)
  );

  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  property p_filter_long;
    (state == scsp_pkg::ST_RUN && pin_low &&
     cnt == scsp_pkg::CNT_W'(scsp_pkg::RST_FILT_CYC)) |=>
      state == scsp_pkg::ST_PIN;
  endproperty
  a_filter_long: assert property (p_filter_long)
    else $error("long reset pulse did not reset");

  property p_filter_short;
    (state == scsp_pkg::ST_RUN &&
     cnt < scsp_pkg::CNT_W'(scsp_pkg::RST_FILT_CYC)) |=>
      state != scsp_pkg::ST_PIN;
  endproperty
  a_filter_short: assert property (p_filter_short)
    else $error("short reset pulse caused reset");

  property p_outs_off;
    in_reset |=> CLK_OUT_EN_O == '0;
  endproperty
  a_outs_off: assert property (p_outs_off)
    else $error("clock outputs enabled during reset");

  property p_por_drive;
    (state == scsp_pkg::ST_POR && next_state == scsp_pkg::ST_POR) |=>
      !RESET_IO_N_OE_N_O && !RESET_IO_N_O;
  endproperty
  a_por_drive: assert property (p_por_drive)
    else $error("reset pin not driven low in power-on");

  property p_mask_default;
    in_reset |=> ctrl == scsp_pkg::CTRL_RST && step == scsp_pkg::STEP_RST;
  endproperty
  a_mask_default: assert property (p_mask_default)
    else $error("config not at default after reset");

  property p_gate;
    (!in_reset && mask[0]) |=> CLK_OUT_EN_O[0] == !$past(OUTPUT_GATE_N_I);
  endproperty
  a_gate: assert property (p_gate)
    else $error("masked output does not follow gate pin");

  property p_irq;
    ($past(REF_LOCK_I) != REF_LOCK_I && !in_reset) |=>
      ##1 !STATUS_IRQ_N_O;
  endproperty
  a_irq: assert property (p_irq)
    else $error("status change did not pull interrupt low");

  property p_lock;
    1'b1 |=> UNLOCK_PLL_FIRST_N_O == $past(PLL_LOCK_I[0]);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock output does not follow lock state");

  sequence s_release;
    in_reset ##1 !in_reset;
  endsequence
  property p_strap;
    s_release |-> BOOT_MODE_O == !$past(BOOT_LOADER_STRAP_N_I);
  endproperty
  a_strap: assert property (p_strap)
    else $error("boot strap not sampled at release");

  property p_stretch;
    scl_fall |=> !SCL_OE_N_O [*8] ##1 SCL_OE_N_O;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock stretch length wrong");
endmodule : scsp_top
